// file: swr_responder.sv
// swr_responder: single-wire return-to-one link responder with pin choice.
// assumes subcommands arrive decoded from the two-wire path, one per pulse,
// and rd_data_i is valid in the same cycle as rd_req_o.
`timescale 1ns/1ps
module swr_responder
#(
	parameter int DEV_SLOT_NS = swr_pkg::DEV_SLOT_NS,
	parameter int DEV_ZERO_LOW_NS = swr_pkg::DEV_ZERO_LOW_NS,
	parameter int DEV_ONE_LOW_NS = swr_pkg::DEV_ONE_LOW_NS,
	parameter int RESP_GAP_NS = swr_pkg::RESP_GAP_NS
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration
	input wire logic [2:0] comm_type_i,
	input wire logic cfg_update_i,
	input wire logic alert_fn_sw_i,
	input wire logic pin_fn_sw_i,
	input wire logic [15:0] bit_thresh_i,
	input wire logic [15:0] break_thresh_i,
	// subcommands from the two-wire path
	input wire logic subcmd_valid_i,
	input wire logic [15:0] subcmd_i,
	// alert pin
	input wire logic alert_in_i,
	output logic alert_out_o,
	output logic alert_oe_o,
	// dedicated single-wire pin
	input wire logic swp_in_i,
	output logic swp_out_o,
	output logic swp_oe_o,
	// status
	output logic swire_active_o,
	output logic swire_on_alert_o,
	// user side write
	output logic wr_valid_o,
	output logic [6:0] wr_cmd_o,
	output logic [7:0] wr_data_o,
	// user side read
	output logic rd_req_o,
	output logic [6:0] rd_cmd_o,
	input wire logic [7:0] rd_data_i
);
	localparam int P = swr_pkg::CLK_PERIOD_NS;
	localparam int SLOT_I = (DEV_SLOT_NS + P - 1) / P;
	localparam int ZERO_I = (DEV_ZERO_LOW_NS + P - 1) / P;
	localparam int ONE_I = (DEV_ONE_LOW_NS + P - 1) / P;
	localparam int GAP_I = (RESP_GAP_NS + P - 1) / P;
	localparam logic [15:0] SLOT_CYC = 16'((SLOT_I < 1) ? 1 : SLOT_I);
	localparam logic [15:0] ZERO_CYC = 16'((ZERO_I < 1) ? 1 : ZERO_I);
	localparam logic [15:0] ONE_CYC = 16'((ONE_I < 1) ? 1 : ONE_I);
	localparam logic [15:0] GAP_CYC = 16'((GAP_I < 1) ? 1 : GAP_I);

	typedef struct packed {
		swr_pkg::swr_mode_t mode;
		swr_pkg::swr_state_t st;
		logic [7:0] shreg;
		logic [7:0] cmdr;
		logic [2:0] nbit;
		logic [15:0] gap;
		logic wr_v;
		logic rd_r;
		logic start;
		logic tbit;
		logic oe_a;
		logic oe_p;
		logic lvl;
		logic active;
		logic on_alert;
	} swr_top_st_t;

	swr_top_st_t r_reg;
	swr_top_st_t r_next;
	logic serve;
	logic rx_line;
	logic rx_bit;
	logic rx_val;
	logic rx_brk;
	logic tx_low;
	logic tx_done;

	// bytes enter at the top so the first slot ends in bit 0
	function automatic logic [7:0] lsb_in(input logic [7:0] sr,
		input logic b);
		lsb_in = {b, sr[7:1]};
	endfunction : lsb_in

	// pin serves only in its mode with its function set
	assign serve = (r_reg.mode == swr_pkg::SWR_MODE_ALERT && alert_fn_sw_i)
		|| (r_reg.mode == swr_pkg::SWR_MODE_PIN && pin_fn_sw_i);
	assign rx_line = (r_reg.mode == swr_pkg::SWR_MODE_PIN) ? swp_in_i
		: alert_in_i;

	// pulse measurement
	swr_rx u_rx
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.line_i(rx_line),
		.bit_thresh_i(bit_thresh_i),
		.break_thresh_i(break_thresh_i),
		.bit_o(rx_bit),
		.bit_val_o(rx_val),
		.brk_o(rx_brk)
	);

	// device slot timing
	swr_tx #(
		.ZERO_CYC(ZERO_CYC),
		.ONE_CYC(ONE_CYC),
		.SLOT_CYC(SLOT_CYC)
	) u_tx
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.start_i(r_reg.start),
		.bit_i(r_reg.tbit),
		.low_o(tx_low),
		.done_o(tx_done)
	);

	// mode selection and frame sequencing
	always_comb
	begin
		r_next = r_reg;
		r_next.wr_v = 1'b0;
		r_next.rd_r = 1'b0;
		r_next.start = 1'b0;
		r_next.lvl = 1'b0;
		if (subcmd_valid_i)
		begin
			if (subcmd_i == swr_pkg::SUB_SWITCH_SW)
				r_next.mode = swr_pkg::SWR_MODE_ALERT;
			else if (subcmd_i == swr_pkg::SUB_SWAP_COMM && !cfg_update_i)
			begin
				if (comm_type_i == swr_pkg::COMM_SW_ALERT)
					r_next.mode = swr_pkg::SWR_MODE_ALERT;
				else if (comm_type_i == swr_pkg::COMM_SW_PIN)
					r_next.mode = swr_pkg::SWR_MODE_PIN;
				else
					r_next.mode = swr_pkg::SWR_MODE_TWO_WIRE;
			end
		end
		r_next.active = serve;
		r_next.on_alert = (r_reg.mode == swr_pkg::SWR_MODE_ALERT);
		if (!serve)
		begin
			r_next.st = swr_pkg::SWR_S_IDLE;
			r_next.nbit = 3'h0;
		end
		else if (rx_brk)
		begin
			r_next.st = swr_pkg::SWR_S_CMD;
			r_next.nbit = 3'h0;
		end
		else
		begin
			case (r_reg.st)
				swr_pkg::SWR_S_IDLE:
					r_next.nbit = 3'h0;
				swr_pkg::SWR_S_CMD:
					if (rx_bit)
					begin
						r_next.shreg = lsb_in(r_reg.shreg, rx_val);
						r_next.nbit = r_reg.nbit + 3'h1;
						if (r_reg.nbit == swr_pkg::LAST_BIT)
						begin
							r_next.cmdr = r_next.shreg;
							if (r_next.shreg[swr_pkg::CMD_DIR_POS])
								r_next.st = swr_pkg::SWR_S_WDATA;
							else
							begin
								r_next.st = swr_pkg::SWR_S_RFETCH;
								r_next.rd_r = 1'b1;
							end
						end
					end
				swr_pkg::SWR_S_WDATA:
					if (rx_bit)
					begin
						r_next.shreg = lsb_in(r_reg.shreg, rx_val);
						r_next.nbit = r_reg.nbit + 3'h1;
						if (r_reg.nbit == swr_pkg::LAST_BIT)
						begin
							r_next.wr_v = 1'b1;
							r_next.st = swr_pkg::SWR_S_IDLE;
						end
					end
				swr_pkg::SWR_S_RFETCH:
				begin
					r_next.shreg = rd_data_i;
					r_next.gap = swr_pkg::CNT_RESET;
					r_next.st = swr_pkg::SWR_S_RGAP;
				end
				swr_pkg::SWR_S_RGAP:
				begin
					r_next.gap = r_reg.gap + 16'h0001;
					if (r_next.gap >= GAP_CYC)
						r_next.st = swr_pkg::SWR_S_RSEND;
				end
				swr_pkg::SWR_S_RSEND:
				begin
					r_next.start = 1'b1;
					r_next.tbit = r_reg.shreg[0];
					r_next.st = swr_pkg::SWR_S_RWAIT;
				end
				swr_pkg::SWR_S_RWAIT:
					if (tx_done)
					begin
						r_next.shreg = {1'b0, r_reg.shreg[7:1]};
						r_next.nbit = r_reg.nbit + 3'h1;
						if (r_reg.nbit == swr_pkg::LAST_BIT)
							r_next.st = swr_pkg::SWR_S_IDLE;
						else
							r_next.st = swr_pkg::SWR_S_RSEND;
					end
				default:
					r_next.st = swr_pkg::SWR_S_IDLE;
			endcase
		end
		// pull low only in read slots on the serving pin
		r_next.oe_a = tx_low && serve && r_reg.st == swr_pkg::SWR_S_RWAIT
			&& r_reg.mode == swr_pkg::SWR_MODE_ALERT;
		r_next.oe_p = tx_low && serve && r_reg.st == swr_pkg::SWR_S_RWAIT
			&& r_reg.mode == swr_pkg::SWR_MODE_PIN;
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			r_reg <= '0;
			r_reg.mode <= swr_pkg::SWR_MODE_TWO_WIRE;
			r_reg.st <= swr_pkg::SWR_S_IDLE;
		end
		else
			r_reg <= r_next;
	end

	// outputs from the state register
	assign alert_out_o = r_reg.lvl;
	assign alert_oe_o = r_reg.oe_a;
	assign swp_out_o = r_reg.lvl;
	assign swp_oe_o = r_reg.oe_p;
	assign swire_active_o = r_reg.active;
	assign swire_on_alert_o = r_reg.on_alert;
	assign wr_valid_o = r_reg.wr_v;
	assign wr_cmd_o = r_reg.cmdr[6:0];
	assign wr_data_o = r_reg.shreg;
	assign rd_req_o = r_reg.rd_r;
	assign rd_cmd_o = r_reg.cmdr[6:0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	switch_alert_a: assert property (
		subcmd_valid_i && subcmd_i == swr_pkg::SUB_SWITCH_SW
		|=> r_reg.mode == swr_pkg::SWR_MODE_ALERT)
		else $error("switch subcommand did not select alert pin");

	swap_pin_a: assert property (
		subcmd_valid_i && subcmd_i == swr_pkg::SUB_SWAP_COMM && !cfg_update_i
		&& comm_type_i == swr_pkg::COMM_SW_PIN
		|=> r_reg.mode == swr_pkg::SWR_MODE_PIN)
		else $error("swap subcommand did not select dedicated pin");

	pin_choice_a: assert property (
		alert_oe_o |-> $past(r_reg.mode) == swr_pkg::SWR_MODE_ALERT
		&& !swp_oe_o)
		else $error("alert pin driven outside alert mode");

	pin_enable_a: assert property (
		swp_oe_o |-> $past(pin_fn_sw_i))
		else $error("dedicated pin driven without its function set");

	drive_low_a: assert property (
		(alert_oe_o || swp_oe_o) |-> !alert_out_o && !swp_out_o)
		else $error("pin driven high");

	read_only_a: assert property (
		$rose(alert_oe_o || swp_oe_o)
		|-> $past(r_reg.st) == swr_pkg::SWR_S_RWAIT && !$past(r_reg.cmdr[7]))
		else $error("line driven outside a read slot");

	write_dir_a: assert property (
		wr_valid_o |-> r_reg.cmdr[swr_pkg::CMD_DIR_POS]
		&& r_reg.st == swr_pkg::SWR_S_IDLE)
		else $error("write delivered without write flag");

	read_dir_a: assert property (
		rd_req_o |-> !r_reg.cmdr[swr_pkg::CMD_DIR_POS]
		##1 r_reg.st == swr_pkg::SWR_S_RGAP && r_reg.shreg == $past(rd_data_i))
		else $error("read byte not captured after request");

	break_reset_a: assert property (
		rx_brk && serve |=> r_reg.st == swr_pkg::SWR_S_CMD && r_reg.nbit == 3'h0)
		else $error("break did not restart the frame");

	one_byte_a: assert property (
		wr_valid_o |=> (!wr_valid_o && !rd_req_o) [*8])
		else $error("second byte in one transaction");

endmodule : swr_responder

// file: swr_pkg.sv
// swr_pkg: constants and types for the single-wire return-to-one responder.
// assumes a 100 MHz core clock; slot times below are plain defaults.
// Notes on behaviour
// - The link runs on the alert pin for communication type 3, on the dedicated pin for 4.
// - The chosen pin serves the link only while its own function is set to single-wire.
// - Both ends only pull the line low through open drain and never drive it high.
// - The switch-to-single-wire subcommand moves the device at once onto the alert pin.
// - The swap subcommand, given outside configuration update, moves to the selected interface.
// - Command and data bytes travel least significant bit first.
// - The command byte holds a 7-bit code in bits 0 to 6 and the direction flag in bit 7.
// - By the direction flag the device takes 8 write bits or drives 8 read bits.
// - The device never starts a transaction and drives only in read-data slots.
// - A host break followed by break recovery resets the frame.
// - The data phase is 8 host slots on a write or 8 device slots on a read.
// - After the low part of a slot the driver releases the line for the rest of it.
// - Each transaction moves exactly one data byte, with no auto-increment.
package swr_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 10;

	// subcommand codes seen on the two-wire path
	localparam logic [15:0] SUB_SWITCH_SW = 16'h7c40;
	localparam logic [15:0] SUB_SWAP_COMM = 16'h29bc;

	// communication-type setting values
	localparam logic [2:0] COMM_SW_ALERT = 3'h3;
	localparam logic [2:0] COMM_SW_PIN = 3'h4;

	// command byte layout
	localparam int CMD_DIR_POS = 7;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// device slot timing in ns
	localparam int DEV_SLOT_NS = 200000;
	localparam int DEV_ZERO_LOW_NS = 150000;
	localparam int DEV_ONE_LOW_NS = 40000;
	localparam int RESP_GAP_NS = 50000;

	// values after reset and the counter limit
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hffff;

	// interface mode
	typedef enum logic [1:0] {
		SWR_MODE_TWO_WIRE,
		SWR_MODE_ALERT,
		SWR_MODE_PIN
	} swr_mode_t;

	// frame states
	typedef enum logic [2:0] {
		SWR_S_IDLE,
		SWR_S_CMD,
		SWR_S_WDATA,
		SWR_S_RFETCH,
		SWR_S_RGAP,
		SWR_S_RSEND,
		SWR_S_RWAIT
	} swr_state_t;

endpackage : swr_pkg

// file: swr_rx.sv
// swr_rx: synchronises the line and measures each low pulse.
// assumes the line idles high through an external pull-up.
`timescale 1ns/1ps
module swr_rx
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// line and thresholds
	input wire logic line_i,
	input wire logic [15:0] bit_thresh_i,
	input wire logic [15:0] break_thresh_i,
	// events
	output logic bit_o,
	output logic bit_val_o,
	output logic brk_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic filt;
		logic [15:0] cnt;
		logic bit_v;
		logic bit_val;
		logic brk;
	} swr_rx_st_t;

	swr_rx_st_t r_reg;
	swr_rx_st_t r_next;

	// three-flop sync, agreement filter, low-width measure
	always_comb
	begin
		r_next = r_reg;
		r_next.s1 = line_i;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.bit_v = 1'b0;
		r_next.brk = 1'b0;
		if (r_reg.s2 == r_reg.s3)
			r_next.filt = r_reg.s3;
		if (!r_reg.filt && r_reg.cnt != swr_pkg::CNT_MAX)
			r_next.cnt = r_reg.cnt + 16'h0001;
		if (r_next.filt && !r_reg.filt)
		begin
			// long low is a break, otherwise width decides the bit
			if (r_reg.cnt >= break_thresh_i)
				r_next.brk = 1'b1;
			else
			begin
				r_next.bit_v = 1'b1;
				r_next.bit_val = (r_reg.cnt < bit_thresh_i);
			end
			r_next.cnt = swr_pkg::CNT_RESET;
		end
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			r_reg <= '0;
			r_reg.s1 <= 1'b1;
			r_reg.s2 <= 1'b1;
			r_reg.s3 <= 1'b1;
			r_reg.filt <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	assign bit_o = r_reg.bit_v;
	assign bit_val_o = r_reg.bit_val;
	assign brk_o = r_reg.brk;

endmodule : swr_rx

// file: swr_tx.sv
// swr_tx: times one device slot, low for the bit's time then released.
// assumes start_i arrives only while idle.
`timescale 1ns/1ps
module swr_tx
#(
	parameter logic [15:0] ZERO_CYC = 16'd15000,
	parameter logic [15:0] ONE_CYC = 16'd4000,
	parameter logic [15:0] SLOT_CYC = 16'd20000
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// slot request
	input wire logic start_i,
	input wire logic bit_i,
	// line pull and completion
	output logic low_o,
	output logic done_o
);
	typedef struct packed {
		logic busy;
		logic low;
		logic done;
		logic [15:0] cnt;
		logic [15:0] low_len;
	} swr_tx_st_t;

	swr_tx_st_t r_reg;
	swr_tx_st_t r_next;

	// slot sequencer
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (!r_reg.busy)
		begin
			if (start_i)
			begin
				r_next.busy = 1'b1;
				r_next.low = 1'b1;
				r_next.cnt = swr_pkg::CNT_RESET;
				r_next.low_len = bit_i ? ONE_CYC : ZERO_CYC;
			end
		end
		else
		begin
			r_next.cnt = r_reg.cnt + 16'h0001;
			if (r_next.cnt >= r_reg.low_len)
				r_next.low = 1'b0;
			if (r_next.cnt >= SLOT_CYC)
			begin
				r_next.busy = 1'b0;
				r_next.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign low_o = r_reg.low;
	assign done_o = r_reg.done;

endmodule : swr_tx

// file: swr_host_model.sv
// swr_host_model: bus controller on the single-wire line.
// assumes an external pull-up; oe_o high pulls the line low.
`timescale 1ns/1ps
module swr_host_model
#(
	parameter int ZERO_LOW = 100,
	parameter int ONE_LOW = 20,
	parameter int SLOT = 160,
	parameter int BREAK_LOW = 300,
	parameter int RECOVERY = 50
)
(
	// clock
	input wire logic clk_i,
	// line
	input wire logic line_i,
	output logic oe_o,
	// last device low widths seen
	output logic [15:0] w0_o,
	output logic [15:0] w1_o
);
	// released at start
	initial
	begin
		oe_o = 1'b0;
		w0_o = 16'h0000;
		w1_o = 16'h0000;
	end
	// break then break_recovery_time
	task brk;
		@(negedge clk_i);
		oe_o = 1'b1;
		repeat (BREAK_LOW) @(negedge clk_i);
		oe_o = 1'b0;
		repeat (RECOVERY) @(negedge clk_i);
	endtask : brk
	// n host slots, lsb first; full low skips the last tail
	task send_bits(input logic [7:0] b, input int n, input bit full);
		int lo;
		@(negedge clk_i);
		for (int i = 0; i < n; i++)
		begin
			lo = b[i] ? ONE_LOW : ZERO_LOW;
			oe_o = 1'b1;
			repeat (lo) @(negedge clk_i);
			oe_o = 1'b0;
			if (full || i < n - 1)
				repeat (SLOT - lo) @(negedge clk_i);
		end
	endtask : send_bits
	// measure 8 device slots; a short low is a one
	task recv(output logic [7:0] b, output bit ok);
		int w;
		int t;
		ok = 1'b1;
		b = 8'h00;
		@(negedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			t = 0;
			while (line_i !== 1'b0 && t < 2000)
			begin
				@(negedge clk_i);
				t++;
			end
			w = 0;
			while (line_i === 1'b0 && w < 2000)
			begin
				w++;
				@(negedge clk_i);
			end
			if (t >= 2000)
				ok = 1'b0;
			b[i] = w < 95;
			if (b[i])
				w1_o = 16'(w);
			else
				w0_o = 16'(w);
		end
	endtask : recv
endmodule : swr_host_model

// file: swr_tb.sv
// swr_tb: self-checking bench for the single-wire responder.
// assumes short slot parameters and the host model on one pin.
`timescale 1ns/1ps
module tb;
	logic clk_i, rst_n_i, cfg_update_i, alert_fn_sw_i, pin_fn_sw_i;
	logic [2:0] comm_type_i;
	logic subcmd_valid_i;
	logic [15:0] subcmd_i, w0, w1, bit_thresh, break_thresh;
	logic [7:0] rd_data_i, wr_data_o, wr_data_s;
	logic alert_out_o, alert_oe_o, swp_out_o, swp_oe_o;
	logic swire_active_o, swire_on_alert_o, wr_valid_o, rd_req_o;
	logic [6:0] wr_cmd_o, rd_cmd_o, wr_cmd_s, rd_cmd_s;
	logic host_oe, sel_swp, alert_in, swp_in, host_line;
	int n_mismatch, comparisons, wr_cnt, rd_cnt, oe_cnt;
	// open-drain wires with pull-ups
	assign alert_in = ~(alert_oe_o | (host_oe & ~sel_swp));
	assign swp_in = ~(swp_oe_o | (host_oe & sel_swp));
	assign host_line = sel_swp ? swp_in : alert_in;
	// clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	swr_responder #(.DEV_SLOT_NS(2000), .DEV_ZERO_LOW_NS(1500),
		.DEV_ONE_LOW_NS(400), .RESP_GAP_NS(500)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .comm_type_i(comm_type_i),
		.cfg_update_i(cfg_update_i), .alert_fn_sw_i(alert_fn_sw_i),
		.pin_fn_sw_i(pin_fn_sw_i), .bit_thresh_i(bit_thresh),
		.break_thresh_i(break_thresh), .subcmd_valid_i(subcmd_valid_i),
		.subcmd_i(subcmd_i), .alert_in_i(alert_in),
		.alert_out_o(alert_out_o), .alert_oe_o(alert_oe_o),
		.swp_in_i(swp_in), .swp_out_o(swp_out_o), .swp_oe_o(swp_oe_o),
		.swire_active_o(swire_active_o),
		.swire_on_alert_o(swire_on_alert_o), .wr_valid_o(wr_valid_o),
		.wr_cmd_o(wr_cmd_o), .wr_data_o(wr_data_o), .rd_req_o(rd_req_o),
		.rd_cmd_o(rd_cmd_o), .rd_data_i(rd_data_i));
	swr_host_model i_host (.clk_i(clk_i), .line_i(host_line),
		.oe_o(host_oe), .w0_o(w0), .w1_o(w1));
	// capture pulses and count device drive cycles
	always @(posedge clk_i)
	begin
		if (wr_valid_o === 1'b1)
		begin
			wr_cnt++;
			wr_cmd_s = wr_cmd_o;
			wr_data_s = wr_data_o;
		end
		if (rd_req_o === 1'b1)
		begin
			rd_cnt++;
			rd_cmd_s = rd_cmd_o;
		end
		if (alert_oe_o !== 1'b0 || swp_oe_o !== 1'b0)
			oe_cnt++;
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task sub(input logic [15:0] code);
		@(negedge clk_i);
		subcmd_valid_i = 1'b1;
		subcmd_i = code;
		@(negedge clk_i);
		subcmd_valid_i = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask : sub
	task t_write(input logic [6:0] c, input logic [7:0] d);
		int c0;
		int t;
		c0 = wr_cnt;
		t = 0;
		oe_cnt = 0;
		i_host.brk();
		i_host.send_bits({1'b1, c}, 8, 1'b1);
		i_host.send_bits(d, 8, 1'b1);
		while (wr_cnt == c0 && t < 5000)
		begin
			@(negedge clk_i);
			t++;
		end
		if (t >= 5000)
		begin
			n_mismatch++;
			close_out();
		end
		check(16'(wr_cnt - c0), 16'h0001);
		check({9'h000, wr_cmd_s}, {9'h000, c});
		check({8'h00, wr_data_s}, {8'h00, d});
		check(16'(oe_cnt), 16'h0000);
		$display("write %h %h done", c, d);
	endtask : t_write
	task t_read(input logic [6:0] c, input logic [7:0] d);
		int c0;
		logic [7:0] b;
		bit ok;
		c0 = rd_cnt;
		rd_data_i = d;
		i_host.brk();
		i_host.send_bits({1'b0, c}, 8, 1'b0);
		i_host.recv(b, ok);
		check({15'h0000, ok}, 16'h0001);
		check({8'h00, b}, {8'h00, d});
		check({9'h000, rd_cmd_s}, {9'h000, c});
		check(16'(rd_cnt - c0), 16'h0001);
		check(w0, 16'h0096);
		check(w1, 16'h0028);
		check({14'h0000, alert_out_o, swp_out_o}, 16'h0000);
		$display("read %h %h done", c, d);
	endtask : t_read
	task t_idle;
		oe_cnt = 0;
		i_host.brk();
		i_host.send_bits(8'h85, 8, 1'b1);
		i_host.send_bits(8'h5a, 8, 1'b1);
		i_host.brk();
		i_host.send_bits(8'h11, 8, 1'b1);
		repeat (300) @(negedge clk_i);
		check(16'(wr_cnt + rd_cnt + oe_cnt), 16'h0000);
		check({15'h0000, swire_active_o}, 16'h0000);
		$display("idle done");
	endtask : t_idle
	task t_switch;
		alert_fn_sw_i = 1'b0;
		sub(16'h7c40);
		check({15'h0000, swire_on_alert_o}, 16'h0001);
		check({15'h0000, swire_active_o}, 16'h0000);
		alert_fn_sw_i = 1'b1;
		repeat (3) @(negedge clk_i);
		check({15'h0000, swire_active_o}, 16'h0001);
		$display("switch done");
	endtask : t_switch
	task t_break;
		int c0;
		i_host.brk();
		i_host.send_bits(8'hff, 4, 1'b1);
		t_write(7'h12, 8'h3c);
		c0 = wr_cnt;
		i_host.send_bits(8'h85, 8, 1'b1);
		i_host.send_bits(8'h77, 8, 1'b1);
		repeat (300) @(negedge clk_i);
		check(16'(wr_cnt - c0), 16'h0000);
		// raised bit threshold: every host low now reads as a one
		bit_thresh = 16'h0080;
		c0 = wr_cnt;
		i_host.brk();
		i_host.send_bits(8'h05, 8, 1'b1);
		i_host.send_bits(8'h00, 8, 1'b1);
		repeat (10) @(negedge clk_i);
		check(16'(wr_cnt - c0), 16'h0001);
		check({8'h00, wr_data_s}, 16'h00ff);
		bit_thresh = 16'h003c;
		$display("break done");
	endtask : t_break
	task t_swap;
		cfg_update_i = 1'b1;
		comm_type_i = 3'h4;
		sub(16'h29bc);
		check({15'h0000, swire_on_alert_o}, 16'h0001);
		cfg_update_i = 1'b0;
		sub(16'h29bc);
		check({15'h0000, swire_on_alert_o}, 16'h0000);
		check({15'h0000, swire_active_o}, 16'h0000);
		pin_fn_sw_i = 1'b1;
		repeat (3) @(negedge clk_i);
		check({15'h0000, swire_active_o}, 16'h0001);
		sel_swp = 1'b1;
		t_write(7'h2a, 8'h81);
		t_read(7'h66, 8'h4d);
		sel_swp = 1'b0;
		comm_type_i = 3'h3;
		sub(16'h29bc);
		check({15'h0000, swire_on_alert_o}, 16'h0001);
		comm_type_i = 3'h0;
		sub(16'h29bc);
		check({15'h0000, swire_active_o}, 16'h0000);
		$display("swap done");
	endtask : t_swap
	// reset, then the scenarios in turn
	initial
	begin
		rst_n_i = 1'b0;
		comm_type_i = 3'h3;
		cfg_update_i = 1'b0;
		alert_fn_sw_i = 1'b1;
		pin_fn_sw_i = 1'b0;
		subcmd_valid_i = 1'b0;
		subcmd_i = 16'h0000;
		rd_data_i = 8'h00;
		bit_thresh = 16'h003c;
		break_thresh = 16'h00fa;
		sel_swp = 1'b0;
		repeat (3) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (5) @(negedge clk_i);
		t_idle();
		t_switch();
		t_write(7'h05, 8'ha6);
		t_write(7'h7f, 8'h00);
		t_write(7'h00, 8'hff);
		t_read(7'h33, 8'h5c);
		t_break();
		t_swap();
		close_out();
	end
endmodule : tb
